/* File: pkg/radio_spi_pkg.sv */
// Constants and types shared by the radio serial slave port
package radio_spi_pkg;
  localparam int ADDR_W = 6;
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_INC_BIT = 6;
  localparam logic [5:0] A_CFG = 6'h00;
  localparam logic [5:0] A_IRQ_EN = 6'h01;
  localparam logic [5:0] A_CLK_CFG = 6'h02;
  localparam logic [5:0] A_TX_STAT = 6'h03;
  localparam logic [5:0] A_RX_STAT = 6'h04;
  localparam logic [5:0] A_SYS_STAT = 6'h05;
  localparam logic [5:0] A_PKT_BUF = 6'h20;
  localparam int PKT_DEPTH = 16;
  // Configuration register fields
  localparam int CFG_FOUR_WIRE = 0;
  localparam int CFG_IRQ_ON_MOSI = 1;
  localparam int CFG_IRQ_ACT_HIGH = 2;
  localparam int CFG_IRQ_OPEN_DRAIN = 3;
  localparam int CFG_MISO_GPIO = 4;
  localparam int CFG_IRQ_GPIO = 5;
  localparam int CFG_MISO_GPIO_VAL = 6;
  localparam int CFG_IRQ_GPIO_VAL = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Interrupt enable fields
  localparam int EN_TX = 0;
  localparam int EN_RX = 1;
  localparam int EN_SYS = 2;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  // Clock output: select in [2:0] (0 = 12 MHz ... 4 = 0.75 MHz), enable
  localparam int CLK_EN_BIT = 3;
  localparam logic [7:0] CLK_CFG_RESET = 8'h08;
  localparam logic [2:0] CLK_SEL_MAX = 3'h4;
  localparam int SYS_OVERRUN_BIT = 7;
  // Crystal-rate clock output from the system clock by phase accumulator
  localparam int MCLK_KHZ = 50000;
  localparam int XTAL_KHZ = 12000;
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC_XTAL =
    NCO_W'((XTAL_KHZ * (2 ** NCO_W)) / MCLK_KHZ);
  typedef struct packed {
    logic [5:0] addr;
    logic [3:0] idx;
    logic [7:0] data;
  } wr_word_type;
  typedef enum logic [0:0] {
    ST_CMD = 1'b0,
    ST_DATA = 1'b1
  } spi_state_type;
endpackage : radio_spi_pkg

/* File: design/radio_spi_slave_irq_port.sv */
// Radio serial slave port with register file, interrupt pin and clock output
`timescale 1ns/100ps
// What this block does
// - Command byte: bit 7 direction (1 write), bit 6 increment, bits 5:0 address.
// - Any number of data bytes follow the command byte.
// - With increment set, address advances by one after each data byte.
// - Without increment, address holds; packet buffer walks its entries.
// - Port logic samples serial clock edges on the system clock, so that clock must run.
// - Serial clock is input only, never driven by the radio.
// - Slave select active low; activity ignored while it is high.
// - Four-wire: data in on master-out, read data out on master-in.
// - Three-wire: radio drives read data on master-out; master releases it.
// - Interrupt on master-out only while slave select is high.
// - Interrupt polarity and push-pull or open-drain output are programmable.
// - Transmit, receive and system groups enabled separately, ORed onto one pin.
// - Status registers show which event raised the interrupt.
// - Event status readable even with its interrupt disabled.
// - Clock output 12, 6, 3, 1.5, 0.75 MHz, enabled at reset.
// - Master-in and interrupt pins can serve as general-purpose outputs.
// - Every register but the packet buffer is reached directly by the six-bit address; its entries sit behind 0x20 and a pointer.
module radio_spi_slave_irq_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  output logic irq_out,
  output logic irq_oe,
  output logic clk_out,
  input wire logic [7:0] tx_event,
  input wire logic [7:0] rx_event,
  input wire logic [7:0] sys_event,
  output logic wr_valid,
  input wire logic wr_ready,
  output radio_spi_pkg::wr_word_type wr_word
);
  logic sclk_q;
  radio_spi_pkg::spi_state_type state, next_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh;
  logic [7:0] tx, next_tx;
  logic rd, next_rd;
  logic inc, next_inc;
  logic [5:0] addr, next_addr;
  logic [3:0] ptr, next_ptr;
  logic rise, fall, push_req;
  radio_spi_pkg::wr_word_type push_word;
  // Two-entry write buffer: head drives the ports, spare absorbs a stall
  radio_spi_pkg::wr_word_type spare, next_spare, next_head;
  logic spare_valid, next_spare_valid, next_head_valid;
  logic full, pop;
  logic [7:0] regs [0:(2**radio_spi_pkg::ADDR_W)-1];
  logic [7:0] pkt [0:radio_spi_pkg::PKT_DEPTH-1];
  logic [7:0] tx_stat, rx_stat, sys_stat;
  logic [7:0] next_tx_stat, next_rx_stat, next_sys_stat;
  logic irq_any, next_irq_any;
  logic next_mosi_out, next_mosi_oe, next_miso_out, next_miso_oe;
  logic next_irq_out, next_irq_oe, irq_level;
  logic [radio_spi_pkg::NCO_W-1:0] nco, next_nco;
  logic [2:0] clk_sel;
  logic next_clk_out;
  logic [7:0] cfg, irq_en, clk_cfg;

  assign cfg = regs[radio_spi_pkg::A_CFG];
  assign irq_en = regs[radio_spi_pkg::A_IRQ_EN];
  assign clk_cfg = regs[radio_spi_pkg::A_CLK_CFG];

  function automatic logic [7:0] read_byte(input logic [5:0] a,
                                           input logic [3:0] p);
    case (a)
      radio_spi_pkg::A_TX_STAT: read_byte = tx_stat;
      radio_spi_pkg::A_RX_STAT: read_byte = rx_stat;
      radio_spi_pkg::A_SYS_STAT: read_byte = sys_stat;
      radio_spi_pkg::A_PKT_BUF: read_byte = pkt[p];
      default: read_byte = regs[a];
    endcase
  endfunction : read_byte

  // Serial clock is only sampled, never driven; no crystal rate involved
  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
  assign full = wr_valid & spare_valid;
  assign pop = wr_valid & wr_ready;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_tx = tx;
    next_rd = rd;
    next_inc = inc;
    next_addr = addr;
    next_ptr = ptr;
    push_req = 1'b0;
    push_word = '0;
    if (ss_n) begin
      next_state = radio_spi_pkg::ST_CMD;
      next_bitcnt = 3'h0;
    end else if (rise) begin
      next_sh = {sh[6:0], mosi_in};
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == 3'h7) begin
        if (state == radio_spi_pkg::ST_CMD) begin
          next_state = radio_spi_pkg::ST_DATA;
          next_rd = ~sh[radio_spi_pkg::CMD_DIR_BIT-1];
          next_inc = sh[radio_spi_pkg::CMD_INC_BIT-1];
          next_addr = {sh[4:0], mosi_in};
          next_ptr = 4'h0;
          next_tx = read_byte({sh[4:0], mosi_in}, 4'h0);
        end else begin
          if (!rd) begin
            push_req = 1'b1;
            push_word = '{addr: addr, idx: ptr, data: {sh[6:0], mosi_in}};
          end
          if (inc) begin
            next_addr = addr + 6'h01;
          end else if (addr == radio_spi_pkg::A_PKT_BUF) begin
            next_ptr = ptr + 4'h1;
          end
          next_tx = read_byte(next_addr, next_ptr);
        end
      end
    end else if (fall && bitcnt != 3'h0) begin
      // The freshly loaded MSB must stand until the first rising edge
      next_tx = {tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      state <= radio_spi_pkg::ST_CMD;
      bitcnt <= 3'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      rd <= 1'b0;
      inc <= 1'b0;
      addr <= 6'h00;
      ptr <= 4'h0;
    end else begin
      sclk_q <= sclk;
      state <= next_state;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      tx <= next_tx;
      rd <= next_rd;
      inc <= next_inc;
      addr <= next_addr;
      ptr <= next_ptr;
    end
  end

  // Serial bytes cannot be paused, so a full buffer loses the byte and
  // flags an overrun rather than corrupting a committed register
  always_comb begin
    next_head = wr_word;
    next_head_valid = wr_valid;
    next_spare = spare;
    next_spare_valid = spare_valid;
    if (pop) begin
      next_head = spare;
      next_head_valid = spare_valid;
      next_spare_valid = 1'b0;
    end
    if (push_req && !full) begin
      if (!next_head_valid) begin
        next_head = push_word;
        next_head_valid = 1'b1;
      end else begin
        next_spare = push_word;
        next_spare_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_word <= '0;
      wr_valid <= 1'b0;
      spare <= '0;
      spare_valid <= 1'b0;
    end else begin
      wr_word <= next_head;
      wr_valid <= next_head_valid;
      spare <= next_spare;
      spare_valid <= next_spare_valid;
    end
  end

  // Writes reach the register file as they leave the buffer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**radio_spi_pkg::ADDR_W; i++) begin
        regs[i] <= 8'h00;
      end
      regs[radio_spi_pkg::A_CFG] <= radio_spi_pkg::CFG_RESET;
      regs[radio_spi_pkg::A_IRQ_EN] <= radio_spi_pkg::IRQ_EN_RESET;
      regs[radio_spi_pkg::A_CLK_CFG] <= radio_spi_pkg::CLK_CFG_RESET;
      for (int j = 0; j < radio_spi_pkg::PKT_DEPTH; j++) begin
        pkt[j] <= 8'h00;
      end
    end else if (pop) begin
      if (wr_word.addr == radio_spi_pkg::A_PKT_BUF) begin
        pkt[wr_word.idx] <= wr_word.data;
      end else begin
        regs[wr_word.addr] <= wr_word.data;
      end
    end
  end

  // Status is sticky, write-one-to-clear, and an event beats its clear
  always_comb begin
    next_tx_stat = tx_stat;
    next_rx_stat = rx_stat;
    next_sys_stat = sys_stat;
    if (pop && wr_word.addr == radio_spi_pkg::A_TX_STAT) begin
      next_tx_stat = tx_stat & ~wr_word.data;
    end
    if (pop && wr_word.addr == radio_spi_pkg::A_RX_STAT) begin
      next_rx_stat = rx_stat & ~wr_word.data;
    end
    if (pop && wr_word.addr == radio_spi_pkg::A_SYS_STAT) begin
      next_sys_stat = sys_stat & ~wr_word.data;
    end
    next_tx_stat = next_tx_stat | tx_event;
    next_rx_stat = next_rx_stat | rx_event;
    next_sys_stat = next_sys_stat | sys_event;
    next_sys_stat[radio_spi_pkg::SYS_OVERRUN_BIT] =
      next_sys_stat[radio_spi_pkg::SYS_OVERRUN_BIT] | (push_req & full);
    next_irq_any = (|tx_stat & irq_en[radio_spi_pkg::EN_TX]) |
                   (|rx_stat & irq_en[radio_spi_pkg::EN_RX]) |
                   (|sys_stat & irq_en[radio_spi_pkg::EN_SYS]);
  end

  // Pin drivers, all registered
  always_comb begin
    irq_level = cfg[radio_spi_pkg::CFG_IRQ_ACT_HIGH] ? irq_any : ~irq_any;
    if (cfg[radio_spi_pkg::CFG_IRQ_OPEN_DRAIN]) begin
      next_irq_out = 1'b0;
      next_irq_oe = ~irq_level;
    end else begin
      next_irq_out = irq_level;
      next_irq_oe = 1'b1;
    end
    if (cfg[radio_spi_pkg::CFG_IRQ_GPIO]) begin
      next_irq_out = cfg[radio_spi_pkg::CFG_IRQ_GPIO_VAL];
      next_irq_oe = 1'b1;
    end
    if (ss_n) begin
      next_mosi_out = next_irq_out;
      next_mosi_oe = cfg[radio_spi_pkg::CFG_IRQ_ON_MOSI] & next_irq_oe;
    end else begin
      next_mosi_out = tx[7];
      next_mosi_oe = ~cfg[radio_spi_pkg::CFG_FOUR_WIRE] & rd &
                     (state == radio_spi_pkg::ST_DATA);
    end
    if (cfg[radio_spi_pkg::CFG_MISO_GPIO]) begin
      next_miso_out = cfg[radio_spi_pkg::CFG_MISO_GPIO_VAL];
      next_miso_oe = 1'b1;
    end else begin
      next_miso_out = tx[7];
      next_miso_oe = ~ss_n & cfg[radio_spi_pkg::CFG_FOUR_WIRE] & rd &
                     (state == radio_spi_pkg::ST_DATA);
    end
    clk_sel = (clk_cfg[2:0] > radio_spi_pkg::CLK_SEL_MAX) ?
              radio_spi_pkg::CLK_SEL_MAX : clk_cfg[2:0];
    // Accumulator gives the right mean rate; edges jitter by one mclk
    next_nco = nco + (radio_spi_pkg::NCO_INC_XTAL >> clk_sel);
    next_clk_out = clk_cfg[radio_spi_pkg::CLK_EN_BIT] &
                   next_nco[radio_spi_pkg::NCO_W-1];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_stat <= 8'h00;
      rx_stat <= 8'h00;
      sys_stat <= 8'h00;
      irq_any <= 1'b0;
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      nco <= '0;
      clk_out <= 1'b0;
    end else begin
      tx_stat <= next_tx_stat;
      rx_stat <= next_rx_stat;
      sys_stat <= next_sys_stat;
      irq_any <= next_irq_any;
      irq_out <= next_irq_out;
      irq_oe <= next_irq_oe;
      mosi_out <= next_mosi_out;
      mosi_oe <= next_mosi_oe;
      miso_out <= next_miso_out;
      miso_oe <= next_miso_oe;
      nco <= next_nco;
      clk_out <= next_clk_out;
    end
  end

  a_cmd_decode: assert property (@(posedge mclk) disable iff (rst)
    (state == radio_spi_pkg::ST_CMD && !ss_n && rise && bitcnt == 3'h7)
    |=> (state == radio_spi_pkg::ST_DATA && rd == ~$past(sh[6]) &&
         inc == $past(sh[5])))
    else $error("command byte decoded wrongly");
  a_addr_advance: assert property (@(posedge mclk) disable iff (rst)
    (state == radio_spi_pkg::ST_DATA && !ss_n && rise && bitcnt == 3'h7 &&
     inc) |=> addr == $past(addr) + 6'h01)
    else $error("burst address did not advance");
  a_addr_hold: assert property (@(posedge mclk) disable iff (rst)
    (state == radio_spi_pkg::ST_DATA && !inc) |=> addr == $past(addr))
    else $error("address moved without increment");
  a_deselect_ends: assert property (@(posedge mclk) disable iff (rst)
    ss_n |=> (state == radio_spi_pkg::ST_CMD && bitcnt == 3'h0))
    else $error("deselect did not end transaction");
  a_mosi_irq_off: assert property (@(posedge mclk) disable iff (rst)
    (!ss_n && state == radio_spi_pkg::ST_CMD) |=> !mosi_oe)
    else $error("master-out driven during command byte");
  a_irq_polarity: assert property (@(posedge mclk) disable iff (rst)
    (!cfg[radio_spi_pkg::CFG_IRQ_OPEN_DRAIN] &&
     !cfg[radio_spi_pkg::CFG_IRQ_GPIO] && irq_any &&
     cfg[radio_spi_pkg::CFG_IRQ_ACT_HIGH]) |=> (irq_out && irq_oe))
    else $error("active-high interrupt not shown");
  a_status_sticky: assert property (@(posedge mclk) disable iff (rst)
    tx_event[0] |=> tx_stat[0] ##1 (tx_stat[0] ||
      $past(pop && wr_word.addr == radio_spi_pkg::A_TX_STAT)))
    else $error("event lost from status");
  a_commit_whole: assert property (@(posedge mclk) disable iff (rst)
    push_req |-> (rise && bitcnt == 3'h7 && !ss_n &&
                  state == radio_spi_pkg::ST_DATA && !rd))
    else $error("write pushed before eight bits");
endmodule : radio_spi_slave_irq_port

/* File: test/spi_master_model.sv */
// Serial master model driving the radio port from the microcontroller side
`timescale 1ns/100ps
module spi_master_model (
  input wire logic mclk,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  output logic sclk,
  output logic ss_n,
  output logic mosi_pin
);
  logic drv_en;
  logic drv_bit;
  logic float_bit;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    drv_en = 1'b0;
    drv_bit = 1'b0;
    float_bit = 1'b0;
  end
  // An undriven line keeps changing so a stale value cannot pass
  always @(posedge mclk) float_bit <= ~float_bit;
  // Both ends driving shows as unknown: a late turnaround is caught
  always_comb begin
    if (mosi_oe && drv_en) mosi_pin = 1'bx;
    else if (mosi_oe) mosi_pin = mosi_out;
    else if (drv_en) mosi_pin = drv_bit;
    else mosi_pin = float_bit;
  end
  task automatic shift_byte(input logic [7:0] tx, input logic drive,
      input logic rel, input logic fw, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      sclk <= 1'b0;
      drv_en <= drive;
      drv_bit <= tx[b];
      repeat (4) @(posedge mclk);
      rx[b] = fw ? (miso_oe ? miso_out : float_bit) : mosi_pin;
      sclk <= 1'b1;
      @(posedge mclk);
      if (b == 0 && rel) drv_en <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : shift_byte
  task automatic transact(input logic [7:0] cmd, input int n,
      input logic fw);
    logic [7:0] rx;
    rx_q.delete();
    @(posedge mclk);
    ss_n <= 1'b0;
    repeat (3) @(posedge mclk);
    shift_byte(cmd, 1'b1, !cmd[7] && !fw, fw, rx);
    for (int i = 0; i < n; i++) begin
      shift_byte(cmd[7] ? tx_q[i] : 8'hFF, cmd[7], 1'b0, fw, rx);
      if (!cmd[7]) rx_q.push_back(rx);
    end
    sclk <= 1'b0;
    drv_en <= 1'b0;
    repeat (4) @(posedge mclk);
    ss_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : transact
endmodule : spi_master_model

/* File: test/radio_spi_slave_irq_port_tb.sv */
// Self-checking testbench for the radio serial slave port
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module radio_spi_slave_irq_port_tb;
  logic mclk, rst, sclk, ss_n, mosi_pin, mosi_out, mosi_oe;
  logic miso_out, miso_oe, irq_out, irq_oe, clk_out, wr_valid, wr_ready;
  logic [7:0] tx_event, rx_event, sys_event;
  radio_spi_pkg::wr_word_type wr_word;
  radio_spi_pkg::wr_word_type wr_q[$];
  int failures = 0;
  int compares = 0;
  int rises = 0;
  radio_spi_slave_irq_port radio_spi_slave_irq_port_i (.mclk, .rst,
    .sclk, .ss_n, .mosi_in(mosi_pin), .mosi_out, .mosi_oe, .miso_out,
    .miso_oe, .irq_out, .irq_oe, .clk_out, .tx_event, .rx_event,
    .sys_event, .wr_valid, .wr_ready, .wr_word);
  spi_master_model spi_master_model_i (.mclk, .mosi_out, .mosi_oe,
    .miso_out, .miso_oe, .sclk, .ss_n, .mosi_pin);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wr_q.push_back(wr_word);
    if ($rose(clk_out)) rises++;
  end
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [5:0] a, input logic inc,
      input logic [7:0] d[$]);
    spi_master_model_i.tx_q = d;
    spi_master_model_i.transact({1'b1, inc, a}, d.size(), 1'b0);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic inc, input logic fw,
      input logic [7:0] e[$]);
    spi_master_model_i.transact({1'b0, inc, a}, e.size(), fw);
    foreach (e[i]) `CHK(spi_master_model_i.rx_q[i], e[i])
  endtask : rd
  task automatic pop_word(input logic [5:0] a, input int i,
      input logic [7:0] d);
    radio_spi_pkg::wr_word_type w;
    `CHK(wr_q.size() > 0, 1'b1)
    w = wr_q.pop_front();
    `CHK(w.addr, a)
    `CHK(w.data, d)
    if (i >= 0) `CHK(w.idx, 4'(i))
  endtask : pop_word
  task automatic pulse(input logic [7:0] t, input logic [7:0] r);
    @(posedge mclk);
    tx_event <= t;
    rx_event <= r;
    @(posedge mclk);
    tx_event <= 8'h00;
    rx_event <= 8'h00;
    repeat (4) @(posedge mclk);
  endtask : pulse
  task automatic clk_rate(input logic [7:0] v, input int e);
    int r0;
    wr(radio_spi_pkg::A_CLK_CFG, 1'b0, '{v});
    pop_word(radio_spi_pkg::A_CLK_CFG, -1, v);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    r0 = rises;
    repeat (400) @(negedge mclk);
    `CHK((rises - r0 >= e - 1) && (rises - r0 <= e + 1), 1'b1)
  endtask : clk_rate
  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    wr_ready = 1'b1;
    tx_event = 8'h00;
    rx_event = 8'h00;
    sys_event = 8'h00;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(irq_oe, 1'b1)
    `CHK(irq_out, 1'b1)
    for (int s = 0; s < 5; s++) clk_rate(8'h08 | 8'(s), 96 >> s);
    clk_rate(8'h00, 0);
    $display("test clock output done");
    wr(6'h06, 1'b1, '{8'hA5, 8'h5A, 8'hC3});
    pop_word(6'h06, -1, 8'hA5);
    pop_word(6'h07, -1, 8'h5A);
    pop_word(6'h08, -1, 8'hC3);
    rd(6'h06, 1'b1, 1'b0, '{8'hA5, 8'h5A, 8'hC3});
    wr(6'h09, 1'b0, '{8'h12, 8'h34});
    pop_word(6'h09, -1, 8'h12);
    pop_word(6'h09, -1, 8'h34);
    rd(6'h09, 1'b0, 1'b0, '{8'h34, 8'h34});
    wr(radio_spi_pkg::A_PKT_BUF, 1'b0, '{8'h11, 8'h22, 8'h33});
    for (int i = 0; i < 3; i++)
      pop_word(radio_spi_pkg::A_PKT_BUF, i, 8'(8'h11 * (i + 1)));
    rd(radio_spi_pkg::A_PKT_BUF, 1'b0, 1'b0, '{8'h11, 8'h22, 8'h33});
    $display("test bursts done");
    wr(radio_spi_pkg::A_IRQ_EN, 1'b0, '{8'h01});
    pulse(8'h00, 8'h04);
    `CHK(irq_out, 1'b1)
    rd(radio_spi_pkg::A_RX_STAT, 1'b0, 1'b0, '{8'h04});
    pulse(8'h01, 8'h00);
    `CHK(irq_out, 1'b0)
    rd(radio_spi_pkg::A_TX_STAT, 1'b0, 1'b0, '{8'h01});
    wr(radio_spi_pkg::A_CFG, 1'b0, '{8'h0B});
    `CHK(irq_oe, 1'b1)
    `CHK(irq_out, 1'b0)
    `CHK(mosi_oe, 1'b1)
    fork
      rd(radio_spi_pkg::A_TX_STAT, 1'b0, 1'b1, '{8'h01});
      begin
        repeat (40) @(posedge mclk);
        `CHK(mosi_oe, 1'b0)
      end
    join
    wr(radio_spi_pkg::A_TX_STAT, 1'b0, '{8'h01});
    `CHK(irq_oe, 1'b0)
    wr(radio_spi_pkg::A_CFG, 1'b0, '{8'h04});
    `CHK(irq_oe, 1'b1)
    `CHK(irq_out, 1'b0)
    wr(radio_spi_pkg::A_CFG, 1'b0, '{8'hF0});
    `CHK(miso_oe, 1'b1)
    `CHK(miso_out, 1'b1)
    `CHK(irq_out, 1'b1)
    wr(radio_spi_pkg::A_CFG, 1'b0, '{8'h30});
    `CHK(miso_out, 1'b0)
    `CHK(irq_out, 1'b0)
    wr(radio_spi_pkg::A_CFG, 1'b0, '{8'h00});
    wr_q.delete();
    $display("test interrupt pin done");
    wr_ready <= 1'b0;
    wr(6'h10, 1'b1, '{8'h01, 8'h02, 8'h03});
    `CHK(wr_valid, 1'b1)
    wr_ready <= 1'b1;
    repeat (8) @(posedge mclk);
    pop_word(6'h10, -1, 8'h01);
    pop_word(6'h11, -1, 8'h02);
    `CHK(wr_q.size(), 0)
    rd(radio_spi_pkg::A_SYS_STAT, 1'b0, 1'b0, '{8'h80});
    $display("test write stall done");
    stop_test();
  end
endmodule : radio_spi_slave_irq_port_tb
